//--- lpmcs_ctrl.v
`timescale 1ns/1ps
`include "lpmcs_map.vh"
module lpmcs_ctrl #(
  parameter WARM_CYCLES = `LPMCS_WARM_CYCLES,
  parameter NUM_INT = 6
) (
  input wire CLK,
  input wire RST,
  input wire [1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [NUM_INT-1:0] EXT_INT,
  input wire [NUM_INT-1:0] EXT_INT_EN,
  input wire ANY_INT,
  input wire RST_PIN,
  input wire SUPPLY_LOW,
  output reg CORE_RUN,
  output reg PERIPH_CLK_EN,
  output reg CRYSTAL_EN,
  output reg RING_EN,
  output reg CLK_SEL_RING,
  output reg WDT_CLK_CRYSTAL,
  output reg BANDGAP_RESET,
  output reg [1:0] CLK_DIV
);
  // ****************************************
  // States
  // ****************************************
  localparam ST_RUN = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_STOP = 3'h2;
  localparam ST_RING = 3'h3;
  localparam ST_WAIT = 3'h4;
  localparam ST_SWAP = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`LPMCS_CNT_W-1:0] cnt_reg;
  reg [`LPMCS_CNT_W-1:0] cnt_next;
  reg ring_select_enable_reg;
  reg bandgap_stop_select_reg;
  reg [1:0] div_reg;
  reg [2:0] swap_reg;
  reg [`LPMCS_SYNC_W-1:0] rst_sync_reg;
  reg [`LPMCS_SYNC_W-1:0] sup_sync_reg;
  reg [NUM_INT-1:0] int_s1_reg;
  reg [NUM_INT-1:0] int_s2_reg;
  reg [NUM_INT-1:0] int_s3_reg;
  reg rst_pin_q;
  reg sup_low_q;
  reg [1:0] div_next;
  wire ring_clock_active_status;
  wire cnt_done;
  wire stop_wake;
  wire wr_ctrl;
  wire wr_div;
  wire wr_flag;

  // ****************************************
  // Helpers
  // ****************************************
  // Ring clock in use in the given state
  function ring_state;
    input [2:0] st;
    begin
      ring_state = (st == ST_RING) || (st == ST_SWAP);
    end
  endfunction

  assign cnt_done = (cnt_reg == WARM_CYCLES[`LPMCS_CNT_W-1:0] - 1'b1);
  assign ring_clock_active_status = ring_state(state_reg);
  assign wr_ctrl = WR && (ADDR == `LPMCS_ADDR_CTRL);
  assign wr_div = WR && (ADDR == `LPMCS_ADDR_DIV);
  assign wr_flag = WR && (ADDR == `LPMCS_ADDR_FLAG);
  // Filtered interrupt: second and third stages agree
  assign stop_wake = |(int_s2_reg & int_s3_reg & EXT_INT_EN);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rst_sync_reg <= 3'h0;
      sup_sync_reg <= 3'h0;
      int_s1_reg <= {NUM_INT{1'b0}};
      int_s2_reg <= {NUM_INT{1'b0}};
      int_s3_reg <= {NUM_INT{1'b0}};
      rst_pin_q <= 1'b0;
      sup_low_q <= 1'b0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], RST_PIN};
      sup_sync_reg <= {sup_sync_reg[1:0], SUPPLY_LOW};
      int_s1_reg <= EXT_INT;
      int_s2_reg <= int_s1_reg;
      int_s3_reg <= int_s2_reg;
      if (rst_sync_reg[1] == rst_sync_reg[2]) begin
        rst_pin_q <= rst_sync_reg[2];
      end
      if (sup_sync_reg[1] == sup_sync_reg[2]) begin
        sup_low_q <= sup_sync_reg[2];
      end
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (wr_ctrl && WDATA[`LPMCS_CTRL_STOP]) begin
          state_next = ST_STOP;
        end else if (wr_ctrl && WDATA[`LPMCS_CTRL_IDLE]) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (ANY_INT) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        cnt_next = {`LPMCS_CNT_W{1'b0}};
        if (stop_wake || rst_pin_q ||
            (bandgap_stop_select_reg && sup_low_q)) begin
          if (ring_select_enable_reg) begin
            state_next = ST_RING;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_RING: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_done) begin
          state_next = ST_SWAP;
        end
      end
      ST_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_done) begin
          state_next = ST_RUN;
        end
      end
      ST_SWAP: begin
        if (swap_reg == 3'h7) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_RUN;
      cnt_reg <= {`LPMCS_CNT_W{1'b0}};
      swap_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == ST_SWAP) begin
        swap_reg <= swap_reg + 1'b1;
      end else begin
        swap_reg <= 3'h0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Divider locked while the ring clock runs or is about to
  always @* begin
    div_next = div_reg;
    if (ring_state(state_reg) || ring_state(state_next)) begin
      div_next = `LPMCS_CD_RESET;
    end else if (wr_div) begin
      div_next = WDATA[`LPMCS_DIV_HI:`LPMCS_DIV_LO];
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ring_select_enable_reg <= 1'b0;
      bandgap_stop_select_reg <= 1'b0;
      div_reg <= `LPMCS_CD_RESET;
    end else begin
      if (wr_flag) begin
        ring_select_enable_reg <= WDATA[`LPMCS_FLAG_RING_SEL];
      end
      if (wr_ctrl) begin
        bandgap_stop_select_reg <= WDATA[`LPMCS_CTRL_BANDGAP];
      end
      div_reg <= div_next;
    end
  end

  // ****************************************
  // Read port and outputs
  // ****************************************
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
      CORE_RUN <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      CRYSTAL_EN <= 1'b1;
      RING_EN <= 1'b0;
      CLK_SEL_RING <= 1'b0;
      WDT_CLK_CRYSTAL <= 1'b1;
      BANDGAP_RESET <= 1'b0;
      CLK_DIV <= `LPMCS_CD_RESET;
    end else begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `LPMCS_ADDR_DIV: RDATA <= {div_reg, 6'h00};
          `LPMCS_ADDR_FLAG: RDATA <= {6'h00, ring_select_enable_reg,
            ring_clock_active_status};
          `LPMCS_ADDR_CTRL: RDATA <= {5'h00, bandgap_stop_select_reg,
            state_reg == ST_STOP, state_reg == ST_IDLE};
          default: RDATA <= 8'h00;
        endcase
      end
      CORE_RUN <= (state_next == ST_RUN) || (state_next == ST_RING) ||
        (state_next == ST_SWAP);
      PERIPH_CLK_EN <= (state_next != ST_STOP);
      CRYSTAL_EN <= (state_next != ST_STOP);
      RING_EN <= ring_state(state_next);
      // Mux select moves to the ring on a stop wake with ring select set, and back to the crystal only after the crystal has run a while
      CLK_SEL_RING <= (state_next == ST_RING) ||
        (state_next == ST_SWAP && swap_reg < 3'h3);
      WDT_CLK_CRYSTAL <= 1'b1;
      BANDGAP_RESET <= (state_reg == ST_STOP) && bandgap_stop_select_reg &&
        sup_low_q;
      // Next value so the lock shows on the first ring cycle
      CLK_DIV <= div_next;
    end
  end
endmodule

//--- lpmcs_map.vh
`ifndef LPMCS_MAP_VH
`define LPMCS_MAP_VH
`define LPMCS_ADDR_DIV 2'h0
`define LPMCS_ADDR_FLAG 2'h1
`define LPMCS_ADDR_CTRL 2'h2
`define LPMCS_CTRL_IDLE 0
`define LPMCS_CTRL_STOP 1
`define LPMCS_CTRL_BANDGAP 2
`define LPMCS_FLAG_RING_SEL 1
`define LPMCS_FLAG_RING_STAT 0
`define LPMCS_DIV_HI 7
`define LPMCS_DIV_LO 6
`define LPMCS_CD_RESET 2'h2
`define LPMCS_WARM_CYCLES 65536
`define LPMCS_CNT_W 17
`define LPMCS_SYNC_W 3
`endif

//--- lpmcs_ctrl_properties.sv
`timescale 1ns/1ps
// ****************
// Mode and clock checks
// ****************
module lpmcs_props #(
  parameter WARM_CYCLES = 16
) (
  input wire CLK,
  input wire RST,
  input wire [1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire CORE_RUN,
  input wire PERIPH_CLK_EN,
  input wire CRYSTAL_EN,
  input wire RING_EN,
  input wire CLK_SEL_RING,
  input wire WDT_CLK_CRYSTAL,
  input wire [1:0] CLK_DIV
);
  int sel_cnt_reg;
  // Cycles spent on the ring clock
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel_cnt_reg <= 0;
    end else begin
      sel_cnt_reg <= CLK_SEL_RING ? sel_cnt_reg + 1 : 0;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_run_wr(logic [1:0] v);
    WR && ADDR == 2'h2 && WDATA[1:0] == v && CORE_RUN && !RING_EN;
  endsequence
  sequence s_wake_slow;
    $rose(CRYSTAL_EN) && !CORE_RUN && !RING_EN;
  endsequence
  property p_wdt; WDT_CLK_CRYSTAL; endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog clock not on crystal");
  property p_idle; s_run_wr(2'h1) |-> ##[1:2] !CORE_RUN && PERIPH_CLK_EN;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle entry wrong");
  property p_stop; s_run_wr(2'h2) |-> ##[1:2] !PERIPH_CLK_EN && !CRYSTAL_EN;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop entry wrong");
  property p_quiet; !PERIPH_CLK_EN |-> !CORE_RUN && !CRYSTAL_EN; endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity while stopped");
  property p_div; RING_EN |-> CLK_DIV == 2'h2; endproperty
  a_div: assert property (p_div)
    else $error("divider not locked on ring");
  property p_sel; CLK_SEL_RING |-> RING_EN && CORE_RUN; endproperty
  a_sel: assert property (p_sel)
    else $error("ring selected while ring off");
  property p_len; $fell(CLK_SEL_RING) |-> sel_cnt_reg >= WARM_CYCLES;
  endproperty
  a_len: assert property (p_len)
    else $error("ring interval too short");
  property p_off; $fell(CLK_SEL_RING) |-> ##[1:8] !RING_EN; endproperty
  a_off: assert property (p_off)
    else $error("ring not switched off");
  property p_wait; s_wake_slow |-> !CORE_RUN [*8]; endproperty
  a_wait: assert property (p_wait)
    else $error("execution before warm-up");
endmodule
bind lpmcs_ctrl lpmcs_props #(.WARM_CYCLES(WARM_CYCLES)) u_lpmcs_props (.*);

//--- lpmcs_ctrl_test.sv
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module lpmcs_ctrl_test;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, ANY_INT = 0, RST_PIN = 0;
  logic SUPPLY_LOW = 0, rd_q = 0;
  logic [1:0] ADDR = 0;
  logic [7:0] WDATA = 0;
  logic [5:0] EXT_INT = 0, EXT_INT_EN = 0, one = 0;
  logic [15:0] q, exp_q[$];
  logic [31:0] seed = 32'h47d0;
  wire [7:0] RDATA, st;
  wire [1:0] CLK_DIV;
  wire CORE_RUN, PERIPH_CLK_EN, CRYSTAL_EN, RING_EN, CLK_SEL_RING;
  wire WDT_CLK_CRYSTAL, BANDGAP_RESET;
  wire [3:0] cond = {BANDGAP_RESET, !RING_EN, CLK_SEL_RING, CORE_RUN};
  int mismatches = 0, checks = 0, n, w;
  assign st = {1'b0, BANDGAP_RESET, WDT_CLK_CRYSTAL, CLK_SEL_RING, RING_EN,
    CRYSTAL_EN, PERIPH_CLK_EN, CORE_RUN};
  always #2.5 CLK = ~CLK;
  lpmcs_ctrl #(.WARM_CYCLES(16)) u_lpmcs_ctrl (.CLK(CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EXT_INT(EXT_INT), .EXT_INT_EN(EXT_INT_EN), .ANY_INT(ANY_INT),
    .RST_PIN(RST_PIN), .SUPPLY_LOW(SUPPLY_LOW), .CORE_RUN(CORE_RUN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .CRYSTAL_EN(CRYSTAL_EN),
    .RING_EN(RING_EN), .CLK_SEL_RING(CLK_SEL_RING),
    .WDT_CLK_CRYSTAL(WDT_CLK_CRYSTAL), .BANDGAP_RESET(BANDGAP_RESET),
    .CLK_DIV(CLK_DIV));
  task check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK) WR <= 0;
    #1;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK) RD <= 0;
    #1;
  endtask
  task wt(input int s);
    n = 0;
    w = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
      w += CRYSTAL_EN;
    end while (n < 300 && cond[s] !== 1'b1);
    if (cond[s] !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t wait limit reached", $time);
    end
  endtask
  task pin;
    @(posedge CLK) RST_PIN <= 1;
    cyc(4);
    @(posedge CLK) RST_PIN <= 0;
  endtask
  // Read data compared against the oldest pending note
  always @(posedge CLK) rd_q <= RD;
  always @(negedge CLK) begin
    if (rd_q) begin
      q = exp_q.pop_front();
      check(RDATA & q[15:8], q[7:0]);
    end
  end
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 0;
    rd(2'h0, 8'hc0, 8'h80);
    rd(2'h1, 8'h01, 8'h00);
    wr(2'h0, 8'hc0);
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h01, 8'h01);
    check(st, 8'h26);
    @(posedge CLK) ANY_INT <= 1;
    @(posedge CLK) ANY_INT <= 0;
    cyc(2);
    check(st, 8'h27);
    rd(2'h2, 8'h01, 8'h00);
    wr(2'h2, 8'h01);
    @(posedge CLK) RST <= 1;
    @(posedge CLK) RST <= 0;
    cyc(1);
    check(st, 8'h27);
    rd(2'h0, 8'hc0, 8'h80);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    one = 6'h1 << (seed % 6);
    @(posedge CLK) EXT_INT_EN <= one;
    wr(2'h2, 8'h02);
    @(posedge CLK) EXT_INT <= ~one;
    cyc(10);
    check(st, 8'h20);
    pin;
    wt(0);
    check(w[7:0], 8'h10);
    check(st, 8'h27);
    @(posedge CLK) EXT_INT <= 0;
    wr(2'h1, 8'h02);
    wr(2'h0, 8'hc0);
    wr(2'h2, 8'h02);
    @(posedge CLK) EXT_INT <= one;
    wt(1);
    check(st & 8'h1b, 8'h1b);
    rd(2'h1, 8'h03, 8'h03);
    wr(2'h0, {2'h3, seed[5:0]});
    rd(2'h0, 8'hc0, 8'h80);
    wt(2);
    rd(2'h1, 8'h01, 8'h00);
    check(st, 8'h27);
    wr(2'h0, 8'hc0);
    rd(2'h0, 8'hc0, 8'hc0);
    @(posedge CLK) EXT_INT <= 0;
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h06);
    @(posedge CLK) SUPPLY_LOW <= 1;
    wt(3);
    check(st & 8'h40, 8'h40);
    @(posedge CLK) SUPPLY_LOW <= 0;
    wt(0);
    wr(2'h2, 8'h02);
    @(posedge CLK) SUPPLY_LOW <= 1;
    cyc(12);
    check(st, 8'h20);
    @(posedge CLK) SUPPLY_LOW <= 0;
    pin;
    wt(0);
    check(st, 8'h27);
    cyc(4);
    wrap_up;
  end
endmodule
